// File: spi_port_map.svh
// register offsets, field positions, reset values and mode codes of the serial port
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// word-aligned byte offsets on the register bus
`define SPI_OFF_IRQ_EN 8'h00
`define SPI_OFF_IRQ_FLAG 8'h04
`define SPI_OFF_BUF 8'h08
`define SPI_OFF_CTRL1 8'h0C
`define SPI_OFF_CTRL3 8'h10
`define SPI_OFF_STAT 8'h14
`define SPI_OFF_DIV 8'h18

// field positions
`define SPI_IRQ_BIT 3
`define SPI_C1_WRITE_COLLISION_FLAG 7
`define SPI_C1_OVFL 6
`define SPI_C1_EN 5
`define SPI_C1_CKP 4
`define SPI_C3_BUFFER_OVERWRITE_ENABLE 4
`define SPI_ST_SMP 7
`define SPI_ST_CKE 6
`define SPI_ST_BF 0

// mode field codes (low four bits of the first control register)
`define SPI_MODE_MST_DIV4 4'h0
`define SPI_MODE_MST_DIV16 4'h1
`define SPI_MODE_MST_DIV64 4'h2
`define SPI_MODE_MST_TMR 4'h3
`define SPI_MODE_SLV_SS 4'h4
`define SPI_MODE_SLV_NOSS 4'h5
`define SPI_MODE_MST_ADD 4'hA

// half periods of the serial clock in reference clock cycles
`define SPI_HALF_DIV4 10'h002
`define SPI_HALF_DIV16 10'h008
`define SPI_HALF_DIV64 10'h020

// reset values
`define SPI_RST_BYTE 8'h00
`define SPI_RST_MODE 4'h0

`endif

// File: spi_port_pkg.sv
// types shared by the serial port design
package spi_port_pkg;

	typedef enum logic
	{
		XS_IDLE = 1'b0,
		XS_SHIFT = 1'b1
	} xfer_state_t;

endpackage : spi_port_pkg

// File: spi_master_slave_port.sv
// serial peripheral port, master and slave roles, with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "spi_port_map.svh"

module spi_master_slave_port #(
	parameter int DIV_W = 8
)(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic ss_n,
	input wire logic sleep_req,
	input wire logic period_timer_tick,
	output logic wake_irq
);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	generate
		if (DIV_W < 1 || DIV_W > 8)
		begin : g_bad_div_w
			$error("DIV_W must lie between 1 and 8");
		end
	endgenerate

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic irq_en;
		logic irq_flag;
		logic [7:0] xfer_buffer;
		logic [7:0] shift_register;
		logic write_collision_flag;
		logic ovfl;
		logic en;
		logic clock_polarity_bit;
		logic [3:0] mode;
		logic buffer_overwrite_enable;
		logic sample_phase_bit;
		logic cke;
		logic bf;
		logic [DIV_W-1:0] rate_div;
		spi_port_pkg::xfer_state_t xs;
		logic [2:0] bit_cnt;
		logic [DIV_W+1:0] rate_cnt;
		logic sck_lvl;
		logic sck_prev;
		logic in_bit;
		logic sdo;
		logic [7:0] a_off;
		logic a_wr;
		logic a_valid;
		logic [7:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;

	logic is_master;
	logic is_slave;
	logic ss_mode;
	logic selected;
	logic step;
	logic lead;
	logic trail;
	logic done;
	logic inb;
	logic take;
	logic busy;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic mode_is_master(input logic [3:0] m);
		return m == `SPI_MODE_MST_DIV4 || m == `SPI_MODE_MST_DIV16 ||
			m == `SPI_MODE_MST_DIV64 || m == `SPI_MODE_MST_TMR ||
			m == `SPI_MODE_MST_ADD;
	endfunction : mode_is_master

	// edge seen on the external clock, leaving or returning to idle
	function automatic logic clk_edge(input logic now, input logic was,
		input logic idle, input logic leaving);
		if (leaving)
			return now != idle && was == idle;
		return now == idle && was != idle;
	endfunction : clk_edge

	// half period in reference cycles for the counter-driven rates
	function automatic logic [DIV_W+1:0] half_period(input logic [3:0] m,
		input logic [DIV_W-1:0] d);
		logic [DIV_W+1:0] h;
		h = (DIV_W+2)'(`SPI_HALF_DIV4);
		unique case (m)
			`SPI_MODE_MST_DIV16: h = (DIV_W+2)'(`SPI_HALF_DIV16);
			`SPI_MODE_MST_DIV64: h = (DIV_W+2)'(`SPI_HALF_DIV64);
			`SPI_MODE_MST_ADD: h = {1'b0, ({1'b0, d} + 1'b1)} << 1;
			default: h = (DIV_W+2)'(`SPI_HALF_DIV4);
		endcase
		return h;
	endfunction : half_period

	function automatic logic [7:0] reg_read(input logic [7:0] off,
		input state_t r);
		logic [7:0] v;
		v = `SPI_RST_BYTE;
		unique case (off)
			`SPI_OFF_IRQ_EN: v[`SPI_IRQ_BIT] = r.irq_en;
			`SPI_OFF_IRQ_FLAG: v[`SPI_IRQ_BIT] = r.irq_flag;
			`SPI_OFF_BUF: v = r.xfer_buffer;
			`SPI_OFF_CTRL1: v = {r.write_collision_flag, r.ovfl, r.en, r.clock_polarity_bit, r.mode};
			`SPI_OFF_CTRL3: v[`SPI_C3_BUFFER_OVERWRITE_ENABLE] = r.buffer_overwrite_enable;
			`SPI_OFF_STAT:
			begin
				v[`SPI_ST_SMP] = r.sample_phase_bit;
				v[`SPI_ST_CKE] = r.cke;
				v[`SPI_ST_BF] = r.bf;
			end
			`SPI_OFF_DIV: v = 8'(r.rate_div);
			default: v = `SPI_RST_BYTE;
		endcase
		return v;
	endfunction : reg_read

	// ------------------------------------------------------------
	// role and bus decode
	// ------------------------------------------------------------
	assign is_master = mode_is_master(s.mode);
	assign ss_mode = s.mode == `SPI_MODE_SLV_SS;
	assign is_slave = ss_mode || s.mode == `SPI_MODE_SLV_NOSS;
	// select gates edges only in the select-controlled slave mode
	assign selected = !ss_mode || !ss_n;
	assign take = hsel && hready && htrans[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		step = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		done = 1'b0;
		inb = 1'b0;
		next_s.sck_prev = sck_in;

		// --------------------------------------------------------
		// bus address phase: latch request, read data ready for data phase
		// --------------------------------------------------------
		next_s.a_valid = take;
		next_s.a_off = haddr[7:0];
		next_s.a_wr = hwrite;
		if (take && !hwrite)
		begin
			next_s.rdata = reg_read(haddr[7:0], s);
			if (haddr[7:0] == `SPI_OFF_BUF)
				next_s.bf = 1'b0;
		end

		// --------------------------------------------------------
		// bus data phase: register writes other than the buffer
		// --------------------------------------------------------
		if (s.a_valid && s.a_wr)
		begin
			unique case (s.a_off)
				`SPI_OFF_IRQ_EN: next_s.irq_en = hwdata[`SPI_IRQ_BIT];
				`SPI_OFF_IRQ_FLAG: next_s.irq_flag = hwdata[`SPI_IRQ_BIT];
				`SPI_OFF_CTRL1:
				begin
					next_s.write_collision_flag = s.write_collision_flag && hwdata[`SPI_C1_WRITE_COLLISION_FLAG];
					next_s.ovfl = s.ovfl && hwdata[`SPI_C1_OVFL];
					next_s.en = hwdata[`SPI_C1_EN];
					next_s.clock_polarity_bit = hwdata[`SPI_C1_CKP];
					next_s.mode = hwdata[3:0];
				end
				`SPI_OFF_CTRL3: next_s.buffer_overwrite_enable = hwdata[`SPI_C3_BUFFER_OVERWRITE_ENABLE];
				`SPI_OFF_STAT:
				begin
					next_s.sample_phase_bit = hwdata[`SPI_ST_SMP];
					next_s.cke = hwdata[`SPI_ST_CKE];
				end
				`SPI_OFF_DIV: next_s.rate_div = hwdata[DIV_W-1:0];
				default: next_s.irq_en = s.irq_en;
			endcase
		end

		// --------------------------------------------------------
		// master clock generation; sleep holds every master-role counter still
		// --------------------------------------------------------
		if (s.en && is_master && s.xs == spi_port_pkg::XS_SHIFT && !sleep_req)
		begin
			if (s.mode == `SPI_MODE_MST_TMR)
				step = period_timer_tick;
			else
				step = s.rate_cnt == half_period(s.mode, s.rate_div) - 1'b1;
			next_s.rate_cnt = step ? '0 : s.rate_cnt + 1'b1;
			if (step)
			begin
				next_s.sck_lvl = ~s.sck_lvl;
				lead = s.sck_lvl == s.clock_polarity_bit;
				trail = !lead;
			end
		end

		// --------------------------------------------------------
		// slave edges from the external clock; runs regardless of sleep
		// --------------------------------------------------------
		if (s.en && is_slave && selected)
		begin
			lead = clk_edge(sck_in, s.sck_prev, s.clock_polarity_bit, 1'b1);
			trail = clk_edge(sck_in, s.sck_prev, s.clock_polarity_bit, 1'b0);
		end

		// --------------------------------------------------------
		// shift engine, msb out first, lsb in
		// --------------------------------------------------------
		if (lead)
		begin
			if (s.cke)
				next_s.in_bit = sdi;
			else
				next_s.sdo = s.shift_register[7];
		end
		if (trail)
		begin
			// end-of-bit sampling only makes sense in master role
			inb = (s.cke && !(is_master && s.sample_phase_bit)) ? s.in_bit : sdi;
			next_s.shift_register = {s.shift_register[6:0], inb};
			if (s.cke)
				next_s.sdo = s.shift_register[6];
			next_s.bit_cnt = s.bit_cnt + 3'h1;
			done = s.bit_cnt == 3'h7;
		end
		// --------------------------------------------------------
		// byte complete; an unread slave byte is kept, not overwritten, unless buffer overwrite is enabled
		// --------------------------------------------------------
		if (done)
		begin
			if (s.bf && !s.buffer_overwrite_enable && is_slave)
				next_s.ovfl = 1'b1;
			else
			begin
				next_s.xfer_buffer = {s.shift_register[6:0], inb};
				next_s.bf = 1'b1;
			end
			next_s.irq_flag = 1'b1;
			next_s.xs = spi_port_pkg::XS_IDLE;
		end

		// --------------------------------------------------------
		// buffer write: collision check, then load and start
		// --------------------------------------------------------
		busy = is_master ? s.xs == spi_port_pkg::XS_SHIFT :
			(s.bit_cnt != 3'h0 || trail);
		if (s.a_valid && s.a_wr && s.a_off == `SPI_OFF_BUF)
		begin
			if (busy || s.write_collision_flag || (is_slave && s.bf && !s.buffer_overwrite_enable))
				next_s.write_collision_flag = 1'b1;
			else
			begin
				next_s.xfer_buffer = hwdata[7:0];
				next_s.shift_register = hwdata[7:0];
				next_s.sdo = hwdata[7];
				next_s.bit_cnt = 3'h0;
				if (s.en && is_master)
				begin
					next_s.xs = spi_port_pkg::XS_SHIFT;
					next_s.rate_cnt = '0;
				end
			end
		end

		// --------------------------------------------------------
		// port reset on disable or deselect
		// --------------------------------------------------------
		if (!s.en || (ss_mode && ss_n))
		begin
			next_s.bit_cnt = 3'h0;
			next_s.xs = spi_port_pkg::XS_IDLE;
		end
		if (next_s.xs == spi_port_pkg::XS_IDLE)
		begin
			next_s.sck_lvl = next_s.clock_polarity_bit;
			next_s.rate_cnt = '0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = {24'h00_0000, s.rdata};
	assign sck_out = s.sck_lvl;
	assign sck_oe = s.en && is_master;
	assign sdo_out = s.sdo;
	// release follows the select pin directly, not a clock later
	assign sdo_oe = s.en && (is_master || (is_slave && selected));
	assign wake_irq = s.irq_flag && s.irq_en;

endmodule : spi_master_slave_port

// File: spi_port_properties.sv
// concurrent checks on the serial port pins and register bus
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_port_properties (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_oe,
	input wire logic ss_n,
	input wire logic sleep_req
);
	// shadow of the last control write, so the role is known from pins
	logic [7:0] ctl;
	logic [7:0] wa;
	logic wp;
	wire logic m0 = ctl[5] && ctl[3:0] == `SPI_MODE_MST_DIV4;
	wire logic m1 = ctl[5] && ctl[3:0] == `SPI_MODE_MST_DIV16;
	wire logic sl = ctl[5] && ctl[3:0] == `SPI_MODE_SLV_SS;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl <= 8'h00;
			wa <= 8'h00;
			wp <= 1'b0;
		end
		else
		begin
			wp <= hsel && hready && htrans[1] && hwrite;
			wa <= haddr[7:0];
			if (wp && wa == `SPI_OFF_CTRL1)
				ctl <= hwdata[7:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	chk_start_clock: assert property (
		m0 && wp && wa == `SPI_OFF_BUF |-> ##[1:6] $changed(sck_out))
		else $error("no clock after buffer write");
	chk_rate_fast: assert property (
		m0 && $changed(sck_out) |=> $stable(sck_out))
		else $error("quarter rate too fast");
	chk_rate_mid: assert property (
		m1 && $changed(sck_out) |=> $stable(sck_out)[*7])
		else $error("sixteenth rate too fast");
	chk_sleep_hold: assert property (
		sck_oe && sleep_req && $past(sleep_req) |-> $stable(sck_out))
		else $error("clock moved in sleep");
	chk_sel_drive: assert property (
		sl && !ss_n |-> sdo_oe)
		else $error("selected slave not driving");
	chk_sel_float: assert property (
		sl && ss_n |-> !sdo_oe)
		else $error("deselected slave driving");
	chk_role_pins: assert property (
		ctl[5] |-> sck_oe == !ctl[2])
		else $error("clock pin direction wrong");
	chk_idle_level: assert property (
		$rose(sck_oe) |=> sck_out == ctl[`SPI_C1_CKP])
		else $error("idle level differs");
	cover property (sl && $rose(ss_n));
	cover property (sck_oe && sleep_req);
	cover property (m1 && $changed(sck_out));
endmodule : spi_port_properties
bind spi_master_slave_port spi_port_properties chk (.*);

// File: spi_far_slave.sv
// far-end serial device answering the port in master role
`timescale 1ns/1ps
module spi_far_slave (
	input wire logic sck,
	input wire logic mosi,
	input wire logic clock_polarity_bit,
	input wire logic cke,
	output logic miso
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	int bits = 0;
	initial miso = 1'b0;
	task automatic load(input logic [7:0] b);
		bits = 0;
		miso = cke ? b[7] : ~miso;
		tx = cke ? b << 1 : b;
	endtask : load
	// released line inverts so a stale bit never passes for data
	always @(sck)
	begin
		if ((sck != clock_polarity_bit) != cke)
		begin
			miso = tx[7];
			tx = tx << 1;
		end
		else
		begin
			rx = {rx[6:0], mosi};
			bits++;
			if (bits == 8)
				miso <= #60 ~miso;
		end
	end
endmodule : spi_far_slave

// File: spi_master_slave_port_tb_top.sv
// self-checking bench of the serial port
`timescale 1ns/1ps
`include "spi_port_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module spi_master_slave_port_tb_top;
	logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic sck_in = 1'b0, sdi = 1'b0, ss_n = 1'b1, sleep_req = 1'b0;
	logic tick = 1'b0, clock_polarity_bit = 1'b0, cke = 1'b0;
	logic hreadyout, hresp, sck_out, sck_oe, sdo_out, sdo_oe, wake_irq, miso;
	logic [31:0] hrdata;
	int failures = 0, checks_done = 0, cyc = 0;
	// master role hears the far device, slave role hears the bench
	wire logic dut_sdi = sck_oe ? miso : sdi;
	spi_master_slave_port uut (.ref_clk, .arst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .sck_in, .sck_out, .sck_oe, .sdi(dut_sdi), .sdo_out,
		.sdo_oe, .ss_n, .sleep_req, .period_timer_tick(tick), .wake_irq);
	spi_far_slave far (.sck(sck_out), .mosi(sdo_out), .clock_polarity_bit, .cke, .miso);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk)
	begin
		cyc++;
		tick <= cyc % 5 == 0;
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end
	task automatic bus(input logic [7:0] a, input logic [7:0] d,
		input logic w, output logic [7:0] v);
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		v = hrdata[7:0];
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		bus(a, d, 1'b1, v);
	endtask : wr
	task automatic wait_bf();
		logic [7:0] v;
		v = 8'h00;
		for (int n = 0; n < 400 && v[0] !== 1'b1; n++)
			bus(`SPI_OFF_STAT, 8'h00, 1'b0, v);
	endtask : wait_bf
	task automatic t_master();
		logic [3:0] md [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
		int hp [5] = '{2, 8, 32, 5, 6};
		logic [7:0] tx, v;
		int t0;
		wr(`SPI_OFF_DIV, 8'h02);
		for (int i = 0; i < 5; i++)
		begin
			tx = 8'h3C + 8'(i * 17);
			{cke, clock_polarity_bit} = 2'(i);
			wr(`SPI_OFF_CTRL1, {3'b000, clock_polarity_bit, md[i]});
			wr(`SPI_OFF_STAT, {1'b0, cke, 6'h00});
			wr(`SPI_OFF_CTRL1, {3'b001, clock_polarity_bit, md[i]});
			bus(`SPI_OFF_CTRL1, 8'h00, 1'b0, v);
			`CHK("control", {3'b001, clock_polarity_bit, md[i]}, v);
			far.load(~tx);
			wr(`SPI_OFF_BUF, tx);
			t0 = cyc;
			repeat (8) @(posedge ref_clk);
			sleep_req <= 1'b1;
			repeat (6) @(posedge ref_clk);
			sleep_req <= 1'b0;
			wait_bf();
			`CHK("time", 1'b1, (cyc - t0) inside {[16*hp[i]:16*hp[i]+24]});
			bus(`SPI_OFF_BUF, 8'h00, 1'b0, v);
			`CHK("received", ~tx, v);
			`CHK("sent", tx, far.rx);
			bus(`SPI_OFF_STAT, 8'h00, 1'b0, v);
			`CHK("full", 1'b0, v[0]);
		end
		$display("test master modes done");
	endtask : t_master
	task automatic t_collide();
		logic [7:0] v;
		wr(`SPI_OFF_CTRL1, 8'h20);
		far.load(8'h66);
		wr(`SPI_OFF_BUF, 8'h81);
		wr(`SPI_OFF_BUF, 8'h7E);
		`CHK("response", 1'b0, hresp);
		wait_bf();
		bus(`SPI_OFF_CTRL1, 8'h00, 1'b0, v);
		`CHK("collision", 8'hA0, v);
		`CHK("sent", 8'h81, far.rx);
		bus(`SPI_OFF_BUF, 8'h00, 1'b0, v);
		`CHK("received", 8'h66, v);
		wr(`SPI_OFF_CTRL1, 8'h20);
		$display("test collision done");
	endtask : t_collide
	task automatic sbits(input logic [7:0] b, input int n);
		for (int k = 7; k > 7 - n; k--)
		begin
			sdi <= b[k];
			repeat (3) @(posedge ref_clk);
			sck_in <= 1'b1;
			repeat (3) @(posedge ref_clk);
			sck_in <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
		sdi <= ~sdi;
	endtask : sbits
	task automatic t_slave();
		logic [7:0] v;
		wr(`SPI_OFF_IRQ_EN, 8'h08);
		wr(`SPI_OFF_STAT, 8'h00);
		wr(`SPI_OFF_CTRL1, 8'h24);
		wr(`SPI_OFF_BUF, 8'h5A);
		ss_n <= 1'b0;
		sbits(8'hFF, 3);
		ss_n <= 1'b1;
		sbits(8'h00, 2);
		ss_n <= 1'b0;
		sleep_req <= 1'b1;
		sbits(8'hC3, 8);
		ss_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK("wake", 1'b1, wake_irq);
		sleep_req <= 1'b0;
		bus(`SPI_OFF_IRQ_FLAG, 8'h00, 1'b0, v);
		`CHK("irq flag", 8'h08, v);
		bus(`SPI_OFF_BUF, 8'h00, 1'b0, v);
		`CHK("slave byte", 8'hC3, v);
		ss_n <= 1'b0;
		sbits(8'h96, 8);
		ss_n <= 1'b1;
		wr(`SPI_OFF_BUF, 8'h11);
		bus(`SPI_OFF_CTRL1, 8'h00, 1'b0, v);
		`CHK("refused", 8'hA4, v);
		wr(`SPI_OFF_CTRL1, 8'h24);
		wr(`SPI_OFF_CTRL3, 8'h10);
		wr(`SPI_OFF_BUF, 8'h22);
		bus(`SPI_OFF_CTRL1, 8'h00, 1'b0, v);
		`CHK("overwrite", 8'h24, v);
		$display("test slave done");
	endtask : t_slave
	initial
	begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_master();
		t_collide();
		t_slave();
		give_verdict();
	end
endmodule : spi_master_slave_port_tb_top
